// file: rtl/mitf_pkg.sv
// Purpose: Shared constants and types for the instruction timing and flag block.
// Assumes: One 25 MHz clock; Wishbone classic register port with 32-bit data.
// Notes:   What this block does
// What this block does
// - Taken skip costs two cycles, else one.
// - Writing program counter low costs two cycles.
// - Paired watchdog pre-clears clear both flags.
// - Plain rotates: one cycle, no flag change.
// - Carry rotates: one cycle, carry only.
// - Moves take one cycle, change no flag.
// - Bit clear/set touches only chosen bit.
// - Jump, call and returns take two cycles.
// - Skip on zero byte or chosen bit.
// - Increment/decrement skip when result is zero.
// - Table reads load high register and memory.
// - Nibble swap, in place or to accumulator.
// - Power-down: one cycle, updates both flags.
// - Power-down stops clock, sets sleep flag.
`default_nettype none

package mitf_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam int unsigned ADR_W        = 4;
  localparam logic [3:0]  ADR_STATUS   = 4'h0;
  localparam logic [3:0]  ADR_TBL_PTR  = 4'h4;
  localparam logic [3:0]  ADR_ACC      = 4'h8;
  localparam logic [3:0]  ADR_TBL_HIGH = 4'hC;
  localparam int unsigned ST_CARRY     = 0;
  localparam int unsigned ST_SLEEP     = 1;
  localparam int unsigned ST_EXPIRY    = 2;
  localparam int unsigned ST_STOPPED   = 3;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [7:0]  BYTE_ONE     = 8'h01;
  localparam int unsigned PC_W         = 11;

  // ****************************************************************
  // Operations and carriers
  // ****************************************************************
  typedef enum logic [5:0] {
    OP_NOP, OP_ROT_R_A, OP_ROT_R, OP_ROTC_R_A, OP_ROTC_R,
    OP_ROT_L_A, OP_ROT_L, OP_ROTC_L_A, OP_ROTC_L,
    OP_MOV_A_M, OP_MOV_M_A, OP_MOV_A_X, OP_CLR_BIT, OP_SET_BIT,
    OP_JMP, OP_SKIP_ZERO, OP_SKIP_ZERO_A, OP_SKIP_BIT_ZERO,
    OP_BIT_SKIP_NONZERO, OP_INC_SKIP_ZERO, OP_DEC_SKIP_ZERO,
    OP_INC_SKIP_ZERO_A, OP_DEC_SKIP_ZERO_A, OP_CALL, OP_RET,
    OP_RET_A_X, OP_INTERRUPT_EXIT, OP_TABLE_FETCH_CURRENT_PAGE,
    OP_TABLE_FETCH_LAST_PAGE, OP_CLR_M, OP_SET_M, OP_CLR_WDT,
    OP_WATCHDOG_PRECLEAR_A, OP_WATCHDOG_PRECLEAR_B, OP_SWAP,
    OP_SWAP_A, OP_HALT
  } mitf_op_t;

  typedef struct packed {
    mitf_op_t   op;
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic       dst_pc_low;
  } mitf_instr_t;

  typedef struct packed {
    logic       we;
    logic [7:0] data;
  } mitf_mem_wr_t;

  typedef enum logic [1:0] {PRE_NONE, PRE_A, PRE_B} mitf_pre_t;

endpackage

`default_nettype wire

// file: rtl/mitf_core.sv
// Purpose: Executes rotate, move, bit, branch, skip, table, watchdog and power-down groups with their timing.
// Assumes: Fetch, memory, watchdog and wake logic share clk_i; program memory answers in the request cycle.
// Notes:   Wishbone classic slave gives software the table pointer and a view of flags and accumulator.
`default_nettype none

module mitf_core (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [mitf_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic                         instr_valid_i,
  input  wire mitf_pkg::mitf_instr_t        instr_i,
  output logic                              instr_ready_o,
  input  wire logic [7:0]                   mem_rdata_i,
  input  wire logic [mitf_pkg::PC_W-1:0]    pc_i,
  input  wire logic [15:0]                  prog_word_i,
  input  wire logic                         wdt_timeout_i,
  input  wire logic                         wake_i,
  output mitf_pkg::mitf_mem_wr_t            mem_wr_o,
  output logic      [7:0]                   acc_o,
  output logic                              carry_o,
  output logic                              skip_o,
  output logic                              tbl_req_o,
  output logic      [mitf_pkg::PC_W-1:0]    tbl_addr_o,
  output logic      [7:0]                   table_high_byte_reg_o,
  output logic                              wdt_clear_o,
  output logic                              clk_stop_o,
  output logic                              wdt_expiry_flag_o,
  output logic                              sleep_flag_o
);
  import mitf_pkg::*;

  localparam int unsigned PAGE_W = PC_W - 8;

  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_SLEEP} mitf_state_t;

  mitf_state_t  state;
  mitf_pre_t    last_pre;
  logic [7:0]   tbl_ptr;
  logic         tbl_pend;
  logic         take;
  logic [7:0]   m;
  logic [7:0]   inc_v;
  logic [7:0]   dec_v;
  logic [7:0]   next_acc;
  logic         next_carry;
  logic         wr_en;
  logic [7:0]   wr_val;
  logic         do_skip;
  logic         fixed_two;
  logic         two_cyc;
  logic         pair_done;
  logic         flag_clear;
  logic         wb_hit;

  assign m     = mem_rdata_i;
  assign inc_v = m + BYTE_ONE;
  assign dec_v = m - BYTE_ONE;
  assign take  = instr_valid_i & instr_ready_o;

  // ****************************************************************
  // Decode and execute
  // ****************************************************************

  // One case computes every data, carry, write and skip effect; unlisted effects keep their old value.
  always_comb begin
    next_acc   = acc_o;
    next_carry = carry_o;
    wr_en      = 1'b0;
    wr_val     = m;
    do_skip    = 1'b0;
    fixed_two  = 1'b0;
    case (instr_i.op)
      OP_ROT_R_A:  next_acc = {m[0], m[7:1]};
      OP_ROT_R: begin
        wr_en  = 1'b1;
        wr_val = {m[0], m[7:1]};
      end
      OP_ROT_L_A:  next_acc = {m[6:0], m[7]};
      OP_ROT_L: begin
        wr_en  = 1'b1;
        wr_val = {m[6:0], m[7]};
      end
      OP_ROTC_R_A: begin
        next_acc   = {carry_o, m[7:1]};
        next_carry = m[0];
      end
      OP_ROTC_R: begin
        wr_en      = 1'b1;
        wr_val     = {carry_o, m[7:1]};
        next_carry = m[0];
      end
      OP_ROTC_L_A: begin
        next_acc   = {m[6:0], carry_o};
        next_carry = m[7];
      end
      OP_ROTC_L: begin
        wr_en      = 1'b1;
        wr_val     = {m[6:0], carry_o};
        next_carry = m[7];
      end
      OP_MOV_A_M:  next_acc = m;
      OP_MOV_A_X:  next_acc = instr_i.imm;
      OP_MOV_M_A: begin
        wr_en  = 1'b1;
        wr_val = acc_o;
      end
      OP_CLR_BIT: begin
        wr_en                  = 1'b1;
        wr_val[instr_i.bit_sel] = 1'b0;
      end
      OP_SET_BIT: begin
        wr_en                  = 1'b1;
        wr_val[instr_i.bit_sel] = 1'b1;
      end
      OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT: fixed_two = 1'b1;
      OP_RET_A_X: begin
        fixed_two = 1'b1;
        next_acc  = instr_i.imm;
      end
      OP_SKIP_ZERO:        do_skip = (m == RST_BYTE);
      OP_SKIP_ZERO_A: begin
        next_acc = m;
        do_skip  = (m == RST_BYTE);
      end
      OP_SKIP_BIT_ZERO:    do_skip = ~m[instr_i.bit_sel];
      OP_BIT_SKIP_NONZERO: do_skip = m[instr_i.bit_sel];
      OP_INC_SKIP_ZERO: begin
        wr_en   = 1'b1;
        wr_val  = inc_v;
        do_skip = (inc_v == RST_BYTE);
      end
      OP_DEC_SKIP_ZERO: begin
        wr_en   = 1'b1;
        wr_val  = dec_v;
        do_skip = (dec_v == RST_BYTE);
      end
      OP_INC_SKIP_ZERO_A: begin
        next_acc = inc_v;
        do_skip  = (inc_v == RST_BYTE);
      end
      OP_DEC_SKIP_ZERO_A: begin
        next_acc = dec_v;
        do_skip  = (dec_v == RST_BYTE);
      end
      OP_TABLE_FETCH_CURRENT_PAGE, OP_TABLE_FETCH_LAST_PAGE: fixed_two = 1'b1;
      OP_CLR_M: begin
        wr_en  = 1'b1;
        wr_val = RST_BYTE;
      end
      OP_SET_M: begin
        wr_en  = 1'b1;
        wr_val = ~RST_BYTE;
      end
      OP_SWAP: begin
        wr_en  = 1'b1;
        wr_val = {m[3:0], m[7:4]};
      end
      OP_SWAP_A:   next_acc = {m[3:0], m[7:4]};
      default:     next_acc = acc_o;
    endcase
  end

  // A memory write aimed at the low program counter forces a pipeline refill.
  assign two_cyc = fixed_two | do_skip | (wr_en & instr_i.dst_pc_low);

  // The pre-clear pair must be back to back, in either order.
  assign pair_done = (instr_i.op == OP_WATCHDOG_PRECLEAR_A && last_pre == PRE_B) ||
                     (instr_i.op == OP_WATCHDOG_PRECLEAR_B && last_pre == PRE_A);
  assign flag_clear = take & (instr_i.op == OP_CLR_WDT | pair_done);

  // ****************************************************************
  // Sequencing
  // ****************************************************************

  // Ready drops for the extra cycle of a two-cycle instruction and while asleep.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_RUN;
    end else begin
      case (state)
        ST_RUN: begin
          if (take && instr_i.op == OP_HALT) begin
            state <= ST_SLEEP;
          end else if (take && two_cyc) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD:  state <= ST_RUN;
        ST_SLEEP: if (wake_i) state <= ST_RUN;
        default:  state <= ST_RUN;
      endcase
    end
  end

  assign instr_ready_o = (state == ST_RUN);
  assign clk_stop_o    = (state == ST_SLEEP);

  // Accumulator and carry; memory is never written by accumulator variants.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_o   <= RST_BYTE;
      carry_o <= 1'b0;
    end else if (take) begin
      acc_o   <= next_acc;
      carry_o <= next_carry;
    end
  end

  // Memory write port; the table read writes its low byte in the cycle after its second cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_wr_o <= '0;
    end else if (tbl_pend) begin
      mem_wr_o <= {1'b1, prog_word_i[7:0]};
    end else begin
      mem_wr_o <= {take & wr_en, wr_val};
    end
  end

  // Table request is raised in the second cycle; the word is taken at the end of that same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbl_req_o             <= 1'b0;
      tbl_pend              <= 1'b0;
      tbl_addr_o            <= '0;
      table_high_byte_reg_o <= RST_BYTE;
    end else begin
      tbl_req_o <= take && fixed_two && (instr_i.op == OP_TABLE_FETCH_CURRENT_PAGE ||
                                         instr_i.op == OP_TABLE_FETCH_LAST_PAGE);
      tbl_pend  <= take && fixed_two && (instr_i.op == OP_TABLE_FETCH_CURRENT_PAGE ||
                                         instr_i.op == OP_TABLE_FETCH_LAST_PAGE);
      if (take && instr_i.op == OP_TABLE_FETCH_LAST_PAGE) begin
        tbl_addr_o <= {{PAGE_W{1'b1}}, tbl_ptr};
      end else if (take && instr_i.op == OP_TABLE_FETCH_CURRENT_PAGE) begin
        tbl_addr_o <= {pc_i[PC_W-1:8], tbl_ptr};
      end
      if (tbl_pend) begin
        table_high_byte_reg_o <= prog_word_i[15:8];
      end
    end
  end

  // Skip and watchdog-clear pulses for the fetch unit and the watchdog.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_o      <= 1'b0;
      wdt_clear_o <= 1'b0;
    end else begin
      skip_o      <= take & do_skip;
      wdt_clear_o <= flag_clear | (take & instr_i.op == OP_HALT);
    end
  end

  // ****************************************************************
  // Watchdog and sleep flags
  // ****************************************************************

  // Any non pre-clear instruction breaks the pair; a repeat restarts it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_pre <= PRE_NONE;
    end else if (take) begin
      if (pair_done || (instr_i.op != OP_WATCHDOG_PRECLEAR_A && instr_i.op != OP_WATCHDOG_PRECLEAR_B)) begin
        last_pre <= PRE_NONE;
      end else if (instr_i.op == OP_WATCHDOG_PRECLEAR_A) begin
        last_pre <= PRE_A;
      end else begin
        last_pre <= PRE_B;
      end
    end
  end

  // A timeout in the same cycle as a clear wins, so no expiry is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_expiry_flag_o <= 1'b0;
    end else if (wdt_timeout_i) begin
      wdt_expiry_flag_o <= 1'b1;
    end else if (flag_clear || (take && instr_i.op == OP_HALT)) begin
      wdt_expiry_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_flag_o <= 1'b0;
    end else if (take && instr_i.op == OP_HALT) begin
      sleep_flag_o <= 1'b1;
    end else if (flag_clear) begin
      sleep_flag_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Wishbone register port
  // ****************************************************************
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Single-wait answer; unmapped reads return zero and writes are dropped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      tbl_ptr  <= RST_BYTE;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= '0;
      if (wb_hit && wb_we_i && wb_adr_i == ADR_TBL_PTR && wb_sel_i[0]) begin
        tbl_ptr <= wb_dat_i[7:0];
      end
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          ADR_STATUS: begin
            wb_dat_o[ST_CARRY]   <= carry_o;
            // The state enum reuses this name locally, so the bit position is scoped to the package.
            wb_dat_o[mitf_pkg::ST_SLEEP] <= sleep_flag_o;
            wb_dat_o[ST_EXPIRY]  <= wdt_expiry_flag_o;
            wb_dat_o[ST_STOPPED] <= clk_stop_o;
          end
          ADR_TBL_PTR:  wb_dat_o[7:0] <= tbl_ptr;
          ADR_ACC:      wb_dat_o[7:0] <= acc_o;
          ADR_TBL_HIGH: wb_dat_o[7:0] <= table_high_byte_reg_o;
          default:      wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tbl_take;
    take && instr_i.op == OP_TABLE_FETCH_LAST_PAGE;
  endsequence

  sequence s_tbl_done;
    mem_wr_o.we && mem_wr_o.data == $past(prog_word_i[7:0]) && table_high_byte_reg_o == $past(prog_word_i[15:8]);
  endsequence

  chk_skip_two_cycles: assert property (take && do_skip |=> !instr_ready_o && skip_o ##1 instr_ready_o)
    else $error("taken skip did not last two cycles");
  chk_noskip_one_cycle: assert property (take && !two_cyc && instr_i.op != OP_HALT |=> instr_ready_o)
    else $error("single-cycle instruction stalled");
  chk_pc_low_refill: assert property (take && wr_en && instr_i.dst_pc_low |=> !instr_ready_o)
    else $error("program counter low write took one cycle");
  chk_pair_clears: assert property (take && pair_done && !wdt_timeout_i |=> !wdt_expiry_flag_o && !sleep_flag_o)
    else $error("pre-clear pair did not clear flags");
  chk_lone_preclear: assert property (take && instr_i.op == OP_WATCHDOG_PRECLEAR_A && last_pre != PRE_B
                                      |=> $stable(sleep_flag_o))
    else $error("lone pre-clear changed sleep flag");
  chk_rotate_wrap: assert property (take && instr_i.op == OP_ROT_R_A
                                    |=> acc_o == {$past(m[0]), $past(m[7:1])} && $stable(carry_o))
    else $error("rotate right wrong or carry touched");
  chk_rotc_carry: assert property (take && instr_i.op == OP_ROTC_L |=> carry_o == $past(m[7]) && mem_wr_o.we)
    else $error("rotate through carry lost outgoing bit");
  chk_bit_set: assert property (take && instr_i.op == OP_SET_BIT
                                |=> mem_wr_o.we && mem_wr_o.data[$past(instr_i.bit_sel)])
    else $error("bit set did not set bit");
  chk_branch_two: assert property (take && instr_i.op == OP_CALL |=> !instr_ready_o ##1 instr_ready_o)
    else $error("call did not take two cycles");
  chk_table_read: assert property (s_tbl_take |=> tbl_req_o ##1 s_tbl_done)
    else $error("table read did not load both bytes");
  chk_acc_keeps_mem: assert property (take && instr_i.op == OP_SWAP_A |=> !mem_wr_o.we)
    else $error("accumulator variant wrote memory");
  chk_halt_flags: assert property (take && instr_i.op == OP_HALT && !wdt_timeout_i
                                   |=> sleep_flag_o && !wdt_expiry_flag_o && clk_stop_o && wdt_clear_o)
    else $error("power-down flags or clock stop wrong");

endmodule

`default_nettype wire

// file: test/mitf_prog_mem.sv
// Purpose: Program memory model that answers table fetches from the core.
// Assumes: Answer is combinational from the registered fetch address.
// Notes:   Outside a fetch the word changes every cycle so stale reads show up.
`default_nettype none

module mitf_prog_mem (
  input  wire logic        clk_i,
  input  wire logic        tbl_req_i,
  input  wire logic [10:0] tbl_addr_i,
  output logic      [15:0] prog_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Word lookup
  // ****************************************************************
  logic [15:0] noise = 16'h1357;

  // Free-running junk so a fetch outside its cycle never sees a stable word.
  always @(posedge clk_i) begin
    noise <= noise + 16'h3C5B;
  end

  // Each address holds a word derived from its own bits, so page errors differ.
  assign prog_word_o = tbl_req_i ? {tbl_addr_i[7:0] ^ {tbl_addr_i[10:8], 5'h0A}, ~tbl_addr_i[7:0]} : noise;
endmodule

`default_nettype wire

// file: test/tb_mcu_instruction_timing_flags.sv
// Purpose: Self-checking bench for instruction timing and flag effects.
// Assumes: Outputs are sampled on the falling edge, inputs change on the rising edge.
// Notes:   Random operations use a fixed seed; watchdog and table cases are directed.
`default_nettype none

`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end

module tb_mcu_instruction_timing_flags;
  timeunit 1ns;
  timeprecision 1ps;
  import mitf_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic          clk = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, valid = 0, wdt_to = 0, wake = 0;
  logic [3:0]    adr = 4'h0, sel = 4'h0;
  logic [31:0]   wdat = 32'h0, wdo, r;
  logic          ack, ready, carry, skip, treq, wclr, cstop, fexp, fslp;
  mitf_instr_t   instr = '0;
  mitf_mem_wr_t  mwr;
  mitf_op_t      op;
  logic [7:0]    mem = 8'h00, acc, thigh, m, x, ptr, e_acc = 8'h00, e_dat;
  logic [10:0]   pc = 11'h000, taddr, ea;
  logic [15:0]   word;
  logic [2:0]    b;
  logic          d, e_c = 0, e_we, e_skip, e_two, e_exp = 0, e_slp = 0;
  int            seed = 32'h1a2f;
  int            miscompares = 0;
  int            n_tests = 0;

  mitf_core dut (.clk_i(clk), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wdo), .wb_ack_o(ack), .instr_valid_i(valid), .instr_i(instr),
    .instr_ready_o(ready), .mem_rdata_i(mem), .pc_i(pc), .prog_word_i(word), .wdt_timeout_i(wdt_to),
    .wake_i(wake), .mem_wr_o(mwr), .acc_o(acc), .carry_o(carry), .skip_o(skip), .tbl_req_o(treq),
    .tbl_addr_o(taddr), .table_high_byte_reg_o(thigh), .wdt_clear_o(wclr), .clk_stop_o(cstop),
    .wdt_expiry_flag_o(fexp), .sleep_flag_o(fslp));
  mitf_prog_mem pm (.clk_i(clk), .tbl_req_i(treq), .tbl_addr_i(taddr), .prog_word_o(word));

  // Clock at 25 MHz.
  always #20 clk = ~clk;

  // ****************************************************************
  // Expectations, drivers and checks
  // ****************************************************************
  // Works out what one taken instruction should leave behind.
  function automatic void model(input mitf_op_t o, input logic [7:0] v, input logic [2:0] i,
                                input logic [7:0] k, input logic dp);
    e_we = 0; e_skip = 0; e_dat = v;
    e_two = o inside {OP_JMP, OP_CALL, OP_RET, OP_RET_A_X, OP_INTERRUPT_EXIT, OP_HALT};
    case (o)
      OP_ROT_R_A, OP_ROT_R: e_dat = {v[0], v[7:1]};
      OP_ROT_L_A, OP_ROT_L: e_dat = {v[6:0], v[7]};
      OP_ROTC_R_A, OP_ROTC_R: begin e_dat = {e_c, v[7:1]}; e_c = v[0]; end
      OP_ROTC_L_A, OP_ROTC_L: begin e_dat = {v[6:0], e_c}; e_c = v[7]; end
      OP_MOV_M_A: e_dat = e_acc;
      OP_MOV_A_X, OP_RET_A_X: e_dat = k;
      OP_CLR_BIT: e_dat = v & ~(8'h01 << i);
      OP_SET_BIT: e_dat = v | (8'h01 << i);
      OP_SKIP_ZERO, OP_SKIP_ZERO_A: e_skip = (v == 8'h00);
      OP_SKIP_BIT_ZERO: e_skip = ~v[i];
      OP_BIT_SKIP_NONZERO: e_skip = v[i];
      OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_A: begin e_dat = v + 8'h01; e_skip = (e_dat == 8'h00); end
      OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_A: begin e_dat = v - 8'h01; e_skip = (e_dat == 8'h00); end
      OP_CLR_M: e_dat = 8'h00;
      OP_SET_M: e_dat = 8'hFF;
      OP_SWAP, OP_SWAP_A: e_dat = {v[3:0], v[7:4]};
      OP_HALT: begin e_exp = 0; e_slp = 1; end
      default: ;
    endcase
    e_we = o inside {OP_ROT_R, OP_ROT_L, OP_ROTC_R, OP_ROTC_L, OP_MOV_M_A, OP_CLR_BIT, OP_SET_BIT,
                     OP_INC_SKIP_ZERO, OP_DEC_SKIP_ZERO, OP_CLR_M, OP_SET_M, OP_SWAP};
    if (o inside {OP_ROT_R_A, OP_ROT_L_A, OP_ROTC_R_A, OP_ROTC_L_A, OP_MOV_A_M, OP_MOV_A_X, OP_SKIP_ZERO_A,
                  OP_INC_SKIP_ZERO_A, OP_DEC_SKIP_ZERO_A, OP_RET_A_X, OP_SWAP_A}) e_acc = e_dat;
    e_two = e_two | e_skip | (dp & e_we);
  endfunction

  // Offers one instruction and returns right after the edge that takes it.
  task automatic issue(input mitf_op_t o, input logic [7:0] v, input logic [2:0] i,
                       input logic [7:0] k, input logic dp);
    valid <= 1'b1;
    instr <= '{o, i, k, dp};
    mem <= v;
    do @(negedge clk); while (ready !== 1'b1);
    @(posedge clk);
    model(o, v, i, k, dp);
  endtask

  // One instruction alone; acc, carry, skip, ready and both flags, plus the memory write when dp is clear, compared one cycle after the take.
  task automatic run(input mitf_op_t o, input logic [7:0] v, input logic [2:0] i,
                     input logic [7:0] k, input logic dp);
    issue(o, v, i, k, dp);
    valid <= 1'b0;
    mem <= ~v;
    @(negedge clk);
    `CHK("acc", e_acc, acc)
    `CHK("carry", e_c, carry)
    `CHK("skip", e_skip, skip)
    `CHK("ready", ~e_two, ready)
    `CHK("expiry", e_exp, fexp)
    `CHK("sleep", e_slp, fslp)
    if (!dp) `CHK("mem_we", e_we, mwr.we)
    if (!dp && e_we) `CHK("mem_data", e_dat, mwr.data)
    if (o == OP_HALT) `CHK("wdt_clear", 1'b1, wclr)
    if (o == OP_HALT) `CHK("clk_stop", 1'b1, cstop)
    @(posedge clk);
  endtask

  // Table fetch: request one cycle after the take, results one cycle later.
  task automatic tbl(input mitf_op_t o);
    issue(o, 8'h00, 3'h0, 8'h00, 1'b0);
    valid <= 1'b0;
    ea = {(o == OP_TABLE_FETCH_LAST_PAGE) ? 3'b111 : pc[10:8], ptr};
    @(negedge clk);
    `CHK("tbl_req", 1'b1, treq)
    `CHK("tbl_addr", ea, taddr)
    `CHK("tbl_ready", 1'b0, ready)
    @(negedge clk);
    `CHK("tbl_low", {1'b1, ~ea[7:0]}, {mwr.we, mwr.data})
    `CHK("tbl_high", ea[7:0] ^ {ea[10:8], 5'h0A}, thigh)
    @(posedge clk);
  endtask

  // Classic Wishbone single cycle, held until ack.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v, output logic [31:0] q);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= v; sel <= 4'hF;
    do @(negedge clk); while (ack !== 1'b1);
    q = wdo;
    @(posedge clk);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask

  // Verdict and end of run.
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Directed corners first, then random operations, then the watchdog pairing.
  initial begin
    repeat (2) @(posedge clk);
    rst_i <= 1'b0;
    @(posedge clk);
    run(OP_ROTC_L, 8'h81, 3'h0, 8'h00, 1'b0);
    run(OP_INC_SKIP_ZERO, 8'hFF, 3'h0, 8'h00, 1'b0);
    run(OP_DEC_SKIP_ZERO_A, 8'h01, 3'h0, 8'h00, 1'b0);
    issue(OP_MOV_A_X, 8'h00, 3'h0, 8'h3C, 1'b0);
    run(OP_MOV_M_A, 8'h00, 3'h0, 8'h00, 1'b1);
    ptr = 8'($random(seed));
    pc <= 11'($random(seed));
    wb(1'b1, ADR_TBL_PTR, {24'h0, ptr}, r);
    wb(1'b0, ADR_TBL_PTR, 32'h0, r);
    `CHK("reg_ptr", {24'h0, ptr}, r)
    wb(1'b1, ADR_ACC, 32'hFF, r);
    wb(1'b0, ADR_ACC, 32'h0, r);
    `CHK("reg_acc", {24'h0, e_acc}, r)
    wb(1'b0, 4'h2, 32'h0, r);
    `CHK("reg_unmapped", 32'h0, r)
    tbl(OP_TABLE_FETCH_CURRENT_PAGE);
    tbl(OP_TABLE_FETCH_LAST_PAGE);
    wb(1'b0, ADR_TBL_HIGH, 32'h0, r);
    `CHK("reg_high", {24'h0, ea[7:0] ^ {ea[10:8], 5'h0A}}, r)
    for (int n = 0; n < 400; n++) begin
      op = mitf_op_t'(6'($unsigned($random(seed)) % 37));
      if (op inside {OP_TABLE_FETCH_CURRENT_PAGE, OP_TABLE_FETCH_LAST_PAGE, OP_CLR_WDT, OP_HALT,
                     OP_WATCHDOG_PRECLEAR_A, OP_WATCHDOG_PRECLEAR_B}) op = OP_NOP;
      m = (n % 6 == 0) ? 8'h00 : (n % 6 == 1) ? 8'hFF : 8'($random(seed));
      b = 3'($random(seed));
      x = 8'($random(seed));
      d = (($random(seed) & 7) == 0);
      run(op, m, b, x, d);
    end
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    e_exp = 1;
    @(posedge clk);
    run(OP_HALT, 8'h00, 3'h0, 8'h00, 1'b0);
    repeat (3) begin @(negedge clk); `CHK("halt_ready", 1'b0, ready) end
    @(posedge clk);
    wake <= 1'b1;
    do @(negedge clk); while (ready !== 1'b1);
    @(posedge clk);
    wake <= 1'b0;
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    e_exp = 1;
    @(posedge clk);
    issue(OP_WATCHDOG_PRECLEAR_A, 8'h00, 3'h0, 8'h00, 1'b0);
    issue(OP_NOP, 8'h00, 3'h0, 8'h00, 1'b0);
    run(OP_WATCHDOG_PRECLEAR_B, 8'h00, 3'h0, 8'h00, 1'b0);
    wb(1'b0, ADR_STATUS, 32'h0, r);
    `CHK("reg_status", {28'h0, 1'b0, e_exp, e_slp, e_c}, r)
    issue(OP_WATCHDOG_PRECLEAR_A, 8'h00, 3'h0, 8'h00, 1'b0);
    e_exp = 0;
    e_slp = 0;
    run(OP_WATCHDOG_PRECLEAR_B, 8'h00, 3'h0, 8'h00, 1'b0);
    stop_test;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #(40 * 40000);
    miscompares++;
    stop_test;
  end
endmodule

`default_nettype wire
